// file: pkg/tcc_pkg.sv
// ============================================================
// shared constants and types for the timer channel
package tcc_pkg;

  // ============================================================
  // register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_MODE   = 8'h04;
  localparam logic [7:0] OFF_COUNT  = 8'h10;
  localparam logic [7:0] OFF_CMPA   = 8'h14;
  localparam logic [7:0] OFF_CMPB   = 8'h18;
  localparam logic [7:0] OFF_TOP    = 8'h1C;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  localparam logic [7:0] OFF_IENSET = 8'h24;
  localparam logic [7:0] OFF_IENCLR = 8'h28;
  localparam logic [7:0] OFF_IMASK  = 8'h2C;

  // ============================================================
  // control command bits and status extras
  localparam int CTRL_CLK_ON   = 0;
  localparam int CTRL_CLK_OFF  = 1;
  localparam int CTRL_SW_TRIG  = 2;
  localparam int STAT_CLK_ON   = 16;
  localparam int STAT_STOPPED  = 17;

  // ============================================================
  // reset values
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;
  localparam logic [15:0] CMP_RESET  = 16'h0000;
  localparam logic [7:0]  EVT_RESET  = 8'h00;

  // ============================================================
  // prescaler taps for internal clocks one to five (clk/2 .. clk/1024)
  localparam int PRE_WIDTH = 10;
  localparam int TAP_ONE   = 0;
  localparam int TAP_TWO   = 2;
  localparam int TAP_THREE = 4;
  localparam int TAP_FOUR  = 6;
  localparam int TAP_FIVE  = 9;

  // ============================================================
  // clock source and gating codes
  localparam logic [2:0] SRC_EXT_ZERO = 3'h5;
  localparam logic [1:0] GATE_NONE    = 2'h0;

  // waveform layout of the mode register, msb first
  typedef struct packed {
    logic [7:0] outBAction;
    logic [7:0] outAAction;
    logic       wave;
    logic [1:0] waveSel;
    logic       extTrigEn;
    logic [1:0] extEvtSel;
    logic [1:0] extEvtEdge;
    logic       disableOnTopMatch;
    logic       stopOnTopMatch;
    logic [1:0] gateSelect;
    logic       countEdgeInvert;
    logic [2:0] countSourceSelect;
  } tcc_mode_t;

  // channel event layout, shared by status, enable and mask
  typedef struct packed {
    logic extTrigger;
    logic loadB;
    logic loadA;
    logic matchTop;
    logic matchB;
    logic matchA;
    logic captureOverrun;
    logic countWrap;
  } tcc_evt_t;

endpackage : tcc_pkg

// file: logic/tcc_clk_sel.sv
`timescale 1ns/10ps
// ============================================================
// counter clock source: prescaler, source mux, gating, edge pick
module tcc_clk_sel (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // selection
  input  wire logic [2:0] srcSel,
  input  wire logic [1:0] gateSel,
  input  wire logic       edgeInv,
  // external clock inputs
  input  wire logic [2:0] extClk,
  // one-cycle count tick
  output logic            countTick
);

  logic [tcc_pkg::PRE_WIDTH-1:0] pre_reg;
  logic [tcc_pkg::PRE_WIDTH-1:0] pre_next;
  logic                          lvl_reg;
  logic                          lvl_next;
  logic [7:0]                    srcVec;
  logic                          selLvl;

  // free prescaler and the gated selected level
  always_comb begin
    pre_next = pre_reg + 1'b1;
    srcVec   = {extClk, pre_reg[tcc_pkg::TAP_FIVE], pre_reg[tcc_pkg::TAP_FOUR],
                pre_reg[tcc_pkg::TAP_THREE], pre_reg[tcc_pkg::TAP_TWO],
                pre_reg[tcc_pkg::TAP_ONE]};
    selLvl   = srcVec[srcSel];
    if (gateSel != tcc_pkg::GATE_NONE) begin
      selLvl = selLvl & extClk[gateSel - 2'd1];
    end
    lvl_next = selLvl;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pre_reg <= '0;
      lvl_reg <= 1'b0;
    end else begin
      pre_reg <= pre_next;
      lvl_reg <= lvl_next;
    end
  end

  // rising edge, or falling edge when inverted
  assign countTick = edgeInv ? (lvl_reg & ~selLvl) : (~lvl_reg & selLvl);

endmodule : tcc_clk_sel

// file: logic/tcc_irq.sv
`timescale 1ns/10ps
// ============================================================
// sticky event flags, mask bits and the level interrupt
module tcc_irq (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // events and software actions
  input  wire tcc_pkg::tcc_evt_t evtPulse,
  input  wire logic             statusRead,
  input  wire logic             maskSetWr,
  input  wire logic             maskClrWr,
  input  wire logic [7:0]       maskData,
  // state
  output tcc_pkg::tcc_evt_t     flags,
  output tcc_pkg::tcc_evt_t     mask,
  output logic                  irq
);

  logic [7:0] flags_reg;
  logic [7:0] flags_next;
  logic [7:0] mask_reg;
  logic [7:0] mask_next;

  // flags clear on read, a new event wins; mask set and clear by ones
  always_comb begin
    flags_next = (statusRead ? 8'h00 : flags_reg) | evtPulse;
    mask_next  = mask_reg;
    if (maskSetWr) begin
      mask_next = mask_reg | maskData;
    end
    if (maskClrWr) begin
      mask_next = mask_reg & ~maskData;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      flags_reg <= tcc_pkg::EVT_RESET;
      mask_reg  <= tcc_pkg::EVT_RESET;
    end else begin
      flags_reg <= flags_next;
      mask_reg  <= mask_next;
    end
  end

  assign flags = flags_reg;
  assign mask  = mask_reg;
  assign irq   = |(flags_reg & mask_reg);

endmodule : tcc_irq

// file: logic/tcc_channel.sv
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/10ps
// Notes on behaviour
// - three-bit source field: codes 0-4 internal clocks one-five, 5-7 external zero-two
// - edge invert 0 counts on rising edge, 1 on falling edge
// - gate field 00 ungated, else AND with external clock zero, one, two
// - stop-on-top-match set: counter clock stops when count reaches top compare
// - disable-on-top-match set: counter clock disabled when count reaches top compare
// - waveform mode register layout, readable and writable, valid while wave bit set
// - writing 1 to enable bit 2 enables compare-A interrupt; 0 no effect
// - writing 1 to enable bit 3 enables compare-B interrupt; 0 no effect
// - writing 1 to enable bit 4 enables top-match interrupt; 0 no effect
// - writing 1 to enable bit 5 enables load-A interrupt; 0 no effect
// - writing 1 to enable bit 6 enables load-B interrupt; 0 no effect
// - writing 1 to enable bit 7 enables external trigger interrupt; 0 no effect
// - writing 1 to wrap enable bit enables counter overflow interrupt
// - writing 1 to overrun enable bit enables load overrun interrupt
module tcc_channel #(
  parameter int CNT_WIDTH = 16
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // register port
  input  wire logic [7:0]           regAddr,
  input  wire logic [31:0]          regWrData,
  input  wire logic                 regWrEn,
  input  wire logic                 regRdEn,
  output logic      [31:0]          regRdData,
  // external clocks and events
  input  wire logic [2:0]           extClk,
  input  wire logic                 extTrigIn,
  input  wire logic [1:0]           loadEvt,
  // status outputs
  output logic      [CNT_WIDTH-1:0] countValue,
  output logic                      clockRunning,
  output logic                      irq
);

  // ============================================================
  // state
  tcc_pkg::tcc_mode_t   mode_reg;
  tcc_pkg::tcc_mode_t   mode_next;
  logic [CNT_WIDTH-1:0] cmpA_reg;
  logic [CNT_WIDTH-1:0] cmpA_next;
  logic [CNT_WIDTH-1:0] cmpB_reg;
  logic [CNT_WIDTH-1:0] cmpB_next;
  logic [CNT_WIDTH-1:0] top_reg;
  logic [CNT_WIDTH-1:0] top_next;
  logic [CNT_WIDTH-1:0] cnt_reg;
  logic [CNT_WIDTH-1:0] cnt_next;
  logic                 clkOn_reg;
  logic                 clkOn_next;
  logic                 stopped_reg;
  logic                 stopped_next;
  logic [31:0]          rdData_reg;
  logic [31:0]          rdData_next;

  // ============================================================
  // decode and internal nets
  logic                 wrCtrl;
  logic                 wrMode;
  logic                 wrCmpA;
  logic                 wrCmpB;
  logic                 wrTop;
  logic                 wrIenSet;
  logic                 wrIenClr;
  logic                 rdStatus;
  logic                 countTick;
  logic                 advance;
  logic                 trigger;
  logic                 topHit;
  tcc_pkg::tcc_evt_t    evt;
  tcc_pkg::tcc_evt_t    flags;
  tcc_pkg::tcc_evt_t    mask;
  logic                 swTrig;
  logic                 hwTrig;
  logic                 clkOnCmd;
  logic                 clkOffCmd;
  logic                 step;
  logic                 hitA;
  logic                 hitB;
  logic                 wrapHit;
  logic                 ovrA;
  logic                 ovrB;

  // ============================================================
  // mode fields in use
  logic [2:0]           srcSel;
  logic [1:0]           gateSel;
  logic                 edgeInv;
  logic                 stopOnTop;
  logic                 disOnTop;
  logic                 extTrigEn;

  // write strobe for one offset
  function automatic logic hitWr(input logic [7:0] a, input logic [7:0] off,
                                 input logic we);
    hitWr = we && (a == off);
  endfunction : hitWr

  // zero-extend a counter-width value to a bus word
  function automatic logic [31:0] toWord(input logic [CNT_WIDTH-1:0] v);
    toWord = 32'(v);
  endfunction : toWord

  // a counted step that lands on a compare value
  function automatic logic reach(input logic s, input logic [CNT_WIDTH-1:0] v,
                                 input logic [CNT_WIDTH-1:0] c);
    reach = s && (v == c);
  endfunction : reach

  // ============================================================
  // address decode
  assign wrCtrl   = hitWr(regAddr, tcc_pkg::OFF_CTRL, regWrEn);
  assign wrMode   = hitWr(regAddr, tcc_pkg::OFF_MODE, regWrEn);
  assign wrCmpA   = hitWr(regAddr, tcc_pkg::OFF_CMPA, regWrEn);
  assign wrCmpB   = hitWr(regAddr, tcc_pkg::OFF_CMPB, regWrEn);
  assign wrTop    = hitWr(regAddr, tcc_pkg::OFF_TOP, regWrEn);
  assign wrIenSet = hitWr(regAddr, tcc_pkg::OFF_IENSET, regWrEn);
  assign wrIenClr = hitWr(regAddr, tcc_pkg::OFF_IENCLR, regWrEn);
  assign rdStatus = hitWr(regAddr, tcc_pkg::OFF_STATUS, regRdEn);

  // ============================================================
  // mode fields that steer the counter
  assign srcSel    = mode_reg.countSourceSelect;
  assign gateSel   = mode_reg.gateSelect;
  assign edgeInv   = mode_reg.countEdgeInvert;
  assign stopOnTop = mode_reg.stopOnTopMatch;
  assign disOnTop  = mode_reg.disableOnTopMatch;
  assign extTrigEn = mode_reg.extTrigEn;

  // ============================================================
  // counter clock selection
  tcc_clk_sel u_clkSel (
    .clk       (clk),
    .rst       (rst),
    .srcSel    (srcSel),
    .gateSel   (gateSel),
    .edgeInv   (edgeInv),
    .extClk    (extClk),
    .countTick (countTick)
  );

  // ============================================================
  // trigger and counting
  // software trigger, or the external trigger when enabled
  assign swTrig    = wrCtrl && regWrData[tcc_pkg::CTRL_SW_TRIG];
  assign hwTrig    = extTrigIn && extTrigEn;
  assign trigger   = swTrig || hwTrig;
  // clock on and off commands from the control word
  assign clkOnCmd  = wrCtrl && regWrData[tcc_pkg::CTRL_CLK_ON];
  assign clkOffCmd = wrCtrl && regWrData[tcc_pkg::CTRL_CLK_OFF];
  // counter advances on a selected edge while enabled and not stopped
  assign advance   = countTick && clkOn_reg && !stopped_reg;
  // a step no trigger overrides, and the compare values it lands on
  assign step      = advance && !trigger;
  assign topHit    = reach(step, cnt_next, top_reg);
  assign hitA      = reach(step, cnt_next, cmpA_reg);
  assign hitB      = reach(step, cnt_next, cmpB_reg);
  assign wrapHit   = step && (cnt_reg == '1);
  // a load while its previous load flag is still pending
  assign ovrA      = loadEvt[0] && flags.loadA;
  assign ovrB      = loadEvt[1] && flags.loadB;

  // next counter value
  always_comb begin
    cnt_next = cnt_reg;
    if (trigger) begin
      cnt_next = '0;
    end else if (advance) begin
      cnt_next = cnt_reg + 1'b1;
    end
  end

  // clock enable: off command beats on, on beats disable-on-top
  always_comb begin
    clkOn_next = clkOn_reg;
    if (topHit && disOnTop) begin
      clkOn_next = 1'b0;
    end
    if (clkOnCmd) begin
      clkOn_next = 1'b1;
    end
    if (clkOffCmd) begin
      clkOn_next = 1'b0;
    end
  end

  // stop state: cleared by a trigger, a top match with stop set wins
  always_comb begin
    stopped_next = stopped_reg;
    if (trigger) begin
      stopped_next = 1'b0;
    end
    if (topHit && stopOnTop) begin
      stopped_next = 1'b1;
    end
  end

  // ============================================================
  // event pulses
  always_comb begin
    evt                = '0;
    evt.countWrap      = wrapHit;
    evt.matchA         = hitA;
    evt.matchB         = hitB;
    evt.matchTop       = topHit;
    evt.loadA          = loadEvt[0];
    evt.loadB          = loadEvt[1];
    evt.captureOverrun = ovrA || ovrB;
    evt.extTrigger     = extTrigIn;
  end

  // ============================================================
  // flags, mask and interrupt
  tcc_irq u_irq (
    .clk        (clk),
    .rst        (rst),
    .evtPulse   (evt),
    .statusRead (rdStatus),
    .maskSetWr  (wrIenSet),
    .maskClrWr  (wrIenClr),
    .maskData   (regWrData[7:0]),
    .flags      (flags),
    .mask       (mask),
    .irq        (irq)
  );

  // ============================================================
  // configuration registers
  always_comb begin
    mode_next = mode_reg;
    cmpA_next = cmpA_reg;
    cmpB_next = cmpB_reg;
    top_next  = top_reg;
    if (wrMode) begin
      mode_next = regWrData;
    end
    if (wrCmpA) begin
      cmpA_next = regWrData[CNT_WIDTH-1:0];
    end
    if (wrCmpB) begin
      cmpB_next = regWrData[CNT_WIDTH-1:0];
    end
    if (wrTop) begin
      top_next = regWrData[CNT_WIDTH-1:0];
    end
  end

  // ============================================================
  // read data, one cycle after the strobe; unmapped reads zero
  always_comb begin
    rdData_next = 32'h0000_0000;
    if (regRdEn) begin
      case (regAddr)
        tcc_pkg::OFF_MODE: begin
          rdData_next = mode_reg;
        end
        tcc_pkg::OFF_COUNT: begin
          rdData_next = toWord(cnt_reg);
        end
        tcc_pkg::OFF_CMPA: begin
          rdData_next = toWord(cmpA_reg);
        end
        tcc_pkg::OFF_CMPB: begin
          rdData_next = toWord(cmpB_reg);
        end
        tcc_pkg::OFF_TOP: begin
          rdData_next = toWord(top_reg);
        end
        tcc_pkg::OFF_STATUS: begin
          rdData_next                         = 32'(flags);
          rdData_next[tcc_pkg::STAT_CLK_ON]   = clkOn_reg;
          rdData_next[tcc_pkg::STAT_STOPPED]  = stopped_reg;
        end
        tcc_pkg::OFF_IMASK: begin
          rdData_next = 32'(mask);
        end
        default: begin
          rdData_next = 32'h0000_0000;
        end
      endcase
    end
  end

  // ============================================================
  // registers
  // counter
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // clock enable
  always_ff @(posedge clk) begin
    if (rst) begin
      clkOn_reg <= 1'b0;
    end else begin
      clkOn_reg <= clkOn_next;
    end
  end

  // stop state
  always_ff @(posedge clk) begin
    if (rst) begin
      stopped_reg <= 1'b0;
    end else begin
      stopped_reg <= stopped_next;
    end
  end

  // configuration
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_reg <= tcc_pkg::MODE_RESET;
      cmpA_reg <= CNT_WIDTH'(tcc_pkg::CMP_RESET);
      cmpB_reg <= CNT_WIDTH'(tcc_pkg::CMP_RESET);
      top_reg  <= CNT_WIDTH'(tcc_pkg::CMP_RESET);
    end else begin
      mode_reg <= mode_next;
      cmpA_reg <= cmpA_next;
      cmpB_reg <= cmpB_next;
      top_reg  <= top_next;
    end
  end

  // read data
  always_ff @(posedge clk) begin
    if (rst) begin
      rdData_reg <= 32'h0000_0000;
    end else begin
      rdData_reg <= rdData_next;
    end
  end

  // ============================================================
  // outputs
  assign regRdData    = rdData_reg;
  assign countValue   = cnt_reg;
  assign clockRunning = clkOn_reg && !stopped_reg;

endmodule : tcc_channel

// file: dv/tcc_channel_checker.sv
`timescale 1ns/10ps
// ====================
// port-level checks for the timer channel
module tcc_channel_checker #(
  parameter int CNT_WIDTH = 16
) (
  // clock and reset
  input wire logic                 clk,
  input wire logic                 rst,
  // register port
  input wire logic [7:0]           regAddr,
  input wire logic [31:0]          regWrData,
  input wire logic                 regWrEn,
  input wire logic                 regRdEn,
  input wire logic [31:0]          regRdData,
  // status
  input wire logic [CNT_WIDTH-1:0] countValue,
  input wire logic                 clockRunning,
  input wire logic                 irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // read data only in the cycle after a read strobe
  a_rd_idle_zero: assert property (!regRdEn |=> regRdData == 32'h0000_0000)
    else $error("read data not zero outside read answer");
  // write-only and unmapped places read as zero
  a_wo_read_zero: assert property (
    regRdEn && (regAddr == 8'h08 || regAddr == 8'h00 || regAddr == 8'h24
    || regAddr == 8'h28) |=> regRdData == 32'h0000_0000)
    else $error("write-only or unmapped read not zero");
  // mask readback holds only the eight event bits
  a_mask_upper_zero: assert property (
    regRdEn && regAddr == 8'h2C |=> regRdData[31:8] == 24'h00_0000)
    else $error("mask readback upper bits set");
  // mode register reads back what was just written
  a_mode_readback: assert property (
    regWrEn && regAddr == 8'h04 ##1 regRdEn && regAddr == 8'h04
    |=> regRdData == $past(regWrData, 2))
    else $error("mode readback mismatch");
  // counter moves by one step or restarts at zero
  a_count_step: assert property (
    countValue != $past(countValue)
    |-> countValue == $past(countValue) + 1'b1 || countValue == '0)
    else $error("counter jumped");
  // no counting while the counter clock is held
  a_stopped_hold: assert property (
    !clockRunning |=> countValue == $past(countValue) || countValue == '0)
    else $error("counter moved while clock held");
  // clock off command wins
  a_off_wins: assert property (
    regWrEn && regAddr == 8'h00 && regWrData[1] |=> !clockRunning)
    else $error("clock still running after off command");
  // clearing every mask bit drops the interrupt in the next cycle
  a_irq_drop: assert property (
    regWrEn && regAddr == 8'h28 && regWrData[7:0] == 8'hFF |=> !irq)
    else $error("interrupt high with empty mask");

  // main scenarios
  c_stop: cover property ($fell(clockRunning));
  c_irq: cover property ($rose(irq));
  c_b2b: cover property (regWrEn ##1 regRdEn);
endmodule : tcc_channel_checker

bind tcc_channel tcc_channel_checker #(.CNT_WIDTH(CNT_WIDTH)) i_chk (
  .clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
  .regRdEn(regRdEn), .regRdData(regRdData), .countValue(countValue),
  .clockRunning(clockRunning), .irq(irq));

// file: dv/tcc_channel_tb.sv
`timescale 1ns/10ps
// ====================
// self-checking bench for the timer channel
module tcc_channel_tb;
  logic        clk, rst, regWrEn, regRdEn, extTrigIn, freeRun, clockRunning, irq;
  logic [7:0]  regAddr;
  logic [31:0] regWrData, regRdData, rdVal, seed, maskM;
  logic [2:0]  extClk, extMan;
  logic [1:0]  loadEvt;
  logic [15:0] countValue, c0;
  int          fails, comparisons;
  int          cyc = 0;
  int          per[8] = '{2, 8, 32, 128, 1024, 4, 16, 64};

  tcc_channel #(.CNT_WIDTH(16)) i_dut (
    .clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regRdData(regRdData), .extClk(extClk), .extTrigIn(extTrigIn),
    .loadEvt(loadEvt), .countValue(countValue), .clockRunning(clockRunning), .irq(irq));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // external clocks: free periods 4, 16, 64 or manual levels
  always @(posedge clk) begin
    cyc <= cyc + 1;
    extClk <= freeRun ? {cyc[5], cyc[3], cyc[1]} : extMan;
  end

  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask : check

  task automatic summarize();
    if (fails == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize

  task automatic waitN(int n);
    repeat (n) @(posedge clk);
  endtask : waitN

  // one write cycle, then one idle cycle
  task automatic wr(logic [7:0] a, logic [31:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk);
    regWrEn <= 1'b0;
    @(posedge clk);
  endtask : wr

  // one read cycle, data taken in the answer cycle
  task automatic rd(logic [7:0] a);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk);
    regRdEn <= 1'b0;
    @(posedge clk);
    rdVal = regRdData;
  endtask : rd

  task automatic rdChk(logic [7:0] a, logic [31:0] e, string n);
    rd(a);
    check(n, rdVal, e);
  endtask : rdChk

  // write followed by read with no gap
  task automatic wrRd(logic [7:0] a, logic [31:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk);
    regWrEn <= 1'b0;
    regRdEn <= 1'b1;
    @(posedge clk);
    regRdEn <= 1'b0;
    @(posedge clk);
    rdVal = regRdData;
  endtask : wrRd

  // counter steps over a window after settling
  task automatic measure(int n, int e, string nm);
    waitN(8);
    c0 = countValue;
    waitN(n);
    check(nm, {16'h0000, countValue - c0}, 32'(e));
  endtask : measure

  task automatic pulse(logic [1:0] l, logic t);
    loadEvt <= l;
    extTrigIn <= t;
    @(posedge clk);
    loadEvt <= 2'h0;
    extTrigIn <= 1'b0;
    @(posedge clk);
  endtask : pulse

  // watchdog
  initial begin
    #1500000;
    fails++;
    summarize();
  end

  // main sequence
  initial begin
    rst = 1'b1;
    {regWrEn, regRdEn, extTrigIn, freeRun} = 4'h0;
    {regAddr, regWrData, loadEvt, extMan} = '0;
    {fails, comparisons, maskM} = '0;
    seed = 32'h775a_3165;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rdChk(tcc_pkg::OFF_MODE, 32'h0000_0000, "mode");
    rdChk(tcc_pkg::OFF_IMASK, 32'h0000_0000, "mask");
    rdChk(8'h08, 32'h0000_0000, "unmapped");
    rdChk(tcc_pkg::OFF_IENSET, 32'h0000_0000, "enable");
    repeat (4) begin
      seed = lfsr(seed);
      wrRd(tcc_pkg::OFF_MODE, seed);
      check("mode", rdVal, seed);
    end
    // enable bits one by one, zero writes in between
    for (int i = 0; i < 8; i++) begin
      wr(tcc_pkg::OFF_IENSET, 32'h1 << i);
      wr(tcc_pkg::OFF_IENSET, 32'h0000_0000);
      maskM[i] = 1'b1;
      rdChk(tcc_pkg::OFF_IMASK, maskM, "mask");
    end
    repeat (8) begin
      seed = lfsr(seed);
      if (seed[8]) maskM[7:0] = maskM[7:0] | seed[7:0];
      else maskM[7:0] = maskM[7:0] & ~seed[7:0];
      wr(seed[8] ? tcc_pkg::OFF_IENSET : tcc_pkg::OFF_IENCLR, seed);
      rdChk(tcc_pkg::OFF_IMASK, maskM, "mask");
    end
    wr(tcc_pkg::OFF_IENCLR, 32'h0000_00FF);
    // every clock source over a 2048-cycle window
    wr(tcc_pkg::OFF_CTRL, 32'h0000_0001);
    freeRun <= 1'b1;
    for (int s = 0; s < 8; s++) begin
      wr(tcc_pkg::OFF_MODE, 32'(s));
      measure(2048, 2048 / per[s], "source");
    end
    // edge choice on external clock zero
    freeRun <= 1'b0;
    for (int v = 0; v < 2; v++) begin
      wr(tcc_pkg::OFF_MODE, 32'h0000_0005 | (32'(v) << 3));
      waitN(8);
      c0 = countValue;
      extMan <= 3'h1;
      waitN(8);
      check("rise", {16'h0000, countValue - c0}, 32'(1 - v));
      extMan <= 3'h0;
      waitN(8);
      check("fall", {16'h0000, countValue - c0}, 32'h0000_0001);
    end
    // gating of clk/2 by each external clock
    for (int g = 1; g < 4; g++) begin
      extMan <= 3'h7 & ~(3'h1 << (g - 1));
      wr(tcc_pkg::OFF_MODE, 32'(g) << 4);
      measure(256, 0, "gated");
      extMan <= 3'h7;
      measure(256, 128, "open");
    end
    // stop on top match, top interrupt masked in
    wr(tcc_pkg::OFF_TOP, 32'h0000_0005);
    wr(tcc_pkg::OFF_IENSET, 32'h0000_0010);
    wr(tcc_pkg::OFF_MODE, 32'h0000_0040);
    rd(tcc_pkg::OFF_STATUS);
    wr(tcc_pkg::OFF_CTRL, 32'h0000_0005);
    waitN(40);
    check("count", {16'h0000, countValue}, 32'h0000_0005);
    check("running", {31'h0, clockRunning}, 32'h0);
    check("irq", {31'h0, irq}, 32'h1);
    rdChk(tcc_pkg::OFF_STATUS, 32'h0003_0010, "status");
    rdChk(tcc_pkg::OFF_STATUS, 32'h0003_0000, "status");
    check("irq", {31'h0, irq}, 32'h0);
    wr(tcc_pkg::OFF_CTRL, 32'h0000_0001);
    waitN(8);
    check("running", {31'h0, clockRunning}, 32'h0);
    // disable on top match, then re-enable and switch off
    wr(tcc_pkg::OFF_MODE, 32'h0000_0080);
    wr(tcc_pkg::OFF_CTRL, 32'h0000_0005);
    waitN(40);
    check("count", {16'h0000, countValue}, 32'h0000_0005);
    rdChk(tcc_pkg::OFF_STATUS, 32'h0000_0010, "status");
    wr(tcc_pkg::OFF_CTRL, 32'h0000_0001);
    waitN(8);
    check("running", {31'h0, clockRunning}, 32'h1);
    wr(tcc_pkg::OFF_CTRL, 32'h0000_0002);
    // load, overrun and trigger events
    wr(tcc_pkg::OFF_IENCLR, 32'h0000_00FF);
    rd(tcc_pkg::OFF_STATUS);
    pulse(2'h1, 1'b0);
    pulse(2'h1, 1'b0);
    pulse(2'h2, 1'b1);
    check("irq", {31'h0, irq}, 32'h0);
    wr(tcc_pkg::OFF_IENSET, 32'h0000_0080);
    check("irq", {31'h0, irq}, 32'h1);
    rdChk(tcc_pkg::OFF_STATUS, 32'h0000_00E2, "status");
    check("irq", {31'h0, irq}, 32'h0);
    summarize();
  end
endmodule : tcc_channel_tb
